// ===== rtl/gpcfg_regs.sv
// Pin-function, switch timer, protection trim and scratch registers
`include "gpcfg_params.svh"
// Operation
// - Function codes 0-2 fail output, 3 cyclic high-side, 4 off.
// - Code 5 makes pin a wake input with 16 us static filter.
// - Code 6 PWM low-side switch, code 7 PWM high-side switch.
// - Function register bits 7:3 read as zero.
// - Power-on loads function code 000.
// - Level-zero lock keeps function field through soft reset.
// - Wake-input pin is a default wake source in fail-safe.
// - Duty 0 off, 255 on, otherwise n/255 on-time.
// - New duty applies from the next period.
// - Period select 00/01/10/11 gives 100/200/325/400 Hz.
// - New frequency applies after current period ends.
// - Duty and period clear on power-on and soft reset; duty kept on restart.
// - Thermal bit 0 default threshold, 1 higher threshold.
// - Limit trim 00 down, 01 default, 10 up one, 11 up two.
// - Protection register powers on as 0000 0001.
// - Level-one lock keeps protection register through soft reset.
// - Scratch bytes clear at power-up, survive soft reset.
// - Scratch writable only in normal mode, readable in stop.
// - Logic never changes scratch; they survive fail-safe and restart.
// - High scratch is bits 15:8, low scratch bits 7:0.
// - Level-zero lock blocks function and charge-pump writes.
// - Level-one lock takes effect at select_n rise, holds to power-up.
module gpcfg_regs
   import gpcfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire gpcfg_req_t  req,
   output      logic [7:0]  rdata,
   input  wire logic        select_n,
   input  wire gpcfg_mode_t mode,
   input  wire logic        soft_reset,
   input  wire logic        restart,
   input  wire logic        lock0,
   input  wire logic        lock1_set,
   input  wire logic        charge_pump_req,
   input  wire logic        wake_pin,
   output      logic        lock1,
   output      logic        charge_pump_on,
   output      gpcfg_pin_t  pin,
   output      logic        wake_level,
   output      logic        thermal_trip_level,
   output      logic [1:0]  regulator_limit_trim,
   output      logic [15:0] scratch_word
);
   localparam int FILT_CYC = `GPCFG_WAKE_FILT_CYC;

   gpcfg_func_t func;
   gpcfg_func_t next_func;
   logic [7:0]  switch_on_ratio;
   logic [7:0]  next_switch_on_ratio;
   logic [1:0]  switch_period_select;
   logic [1:0]  next_switch_period_select;
   logic [2:0]  prot;
   logic [2:0]  next_prot;
   logic [7:0]  scratch_low_byte;
   logic [7:0]  next_scratch_low_byte;
   logic [7:0]  scratch_high_byte;
   logic [7:0]  next_scratch_high_byte;
   logic        lock1_pend;
   logic        next_lock1_pend;
   logic        next_lock1;
   logic        next_charge_pump_on;
   logic [7:0]  next_rdata;
   logic [2:0]  sel_sync;
   logic [2:0]  wake_sync;
   logic        sel_rise;
   logic [11:0] filt_cnt;
   logic [11:0] next_filt_cnt;
   logic        next_wake_level;
   logic        pwm_out;
   logic        lock1_pend_seen;
   logic        next_lock1_pend_seen;

   gpcfg_pwm u_pwm (
      .clk     (clk),
      .rst_n   (rst_n),
      .duty    (switch_on_ratio),
      .freq    (switch_period_select),
      .pwm_out (pwm_out)
   );

   // Select_n and wake pin come from outside the clock domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_sync  <= 3'h7;
         wake_sync <= 3'h0;
      end else begin
         sel_sync  <= {sel_sync[1:0], select_n};
         wake_sync <= {wake_sync[1:0], wake_pin};
      end
   end

   // Rise counted once the second and third stages agree high
   assign sel_rise = sel_sync[1] & sel_sync[2] & ~lock1_pend_seen;

   always_comb begin
      next_func                 = func;
      next_switch_on_ratio      = switch_on_ratio;
      next_switch_period_select = switch_period_select;
      next_prot                 = prot;
      next_scratch_low_byte     = scratch_low_byte;
      next_scratch_high_byte    = scratch_high_byte;
      next_lock1_pend           = lock1_pend;
      next_lock1                = lock1;
      next_charge_pump_on       = charge_pump_on;
      next_lock1_pend_seen      = sel_sync[1] & sel_sync[2];
      if (restart) begin
         next_switch_period_select = 2'h0;
      end else if (soft_reset) begin
         if (!lock0)
            next_func = gpcfg_func_t'(`GPCFG_FUNC_POR);
         next_switch_on_ratio      = `GPCFG_DUTY_POR;
         next_switch_period_select = `GPCFG_PER_POR;
         if (!lock1)
            next_prot = `GPCFG_PROT_POR;
         // Scratch bytes deliberately untouched here
      end else if (req.wr) begin
         case (req.addr)
            `GPCFG_ADDR_FUNC:
               if (!lock0)
                  next_func = gpcfg_func_t'(req.wdata[`GPCFG_FUNC_MSB:0]);
            `GPCFG_ADDR_DUTY:   next_switch_on_ratio = req.wdata;
            `GPCFG_ADDR_PERIOD:
               next_switch_period_select = req.wdata[`GPCFG_PER_MSB:0];
            `GPCFG_ADDR_PROT:
               if (!lock1)
                  next_prot = req.wdata[`GPCFG_PROT_MSB:0];
            `GPCFG_ADDR_SCR_LO:
               if (mode == GPCFG_MODE_NORMAL)
                  next_scratch_low_byte = req.wdata;
            `GPCFG_ADDR_SCR_HI:
               if (mode == GPCFG_MODE_NORMAL)
                  next_scratch_high_byte = req.wdata;
            default: ;
         endcase
      end
      if (!lock0)
         next_charge_pump_on = charge_pump_req;
      if (lock1_set && !lock1)
         next_lock1_pend = 1'b1;
      if (lock1_pend && sel_rise) begin
         next_lock1      = 1'b1;
         next_lock1_pend = 1'b0;
      end
   end

   always_comb begin
      case (req.addr)
         `GPCFG_ADDR_FUNC:   next_rdata = {5'h00, 3'(func)};
         `GPCFG_ADDR_DUTY:   next_rdata = switch_on_ratio;
         `GPCFG_ADDR_PERIOD: next_rdata = {6'h00, switch_period_select};
         `GPCFG_ADDR_PROT:   next_rdata = {5'h00, prot};
         `GPCFG_ADDR_SCR_LO: next_rdata = scratch_low_byte;
         `GPCFG_ADDR_SCR_HI: next_rdata = scratch_high_byte;
         default:            next_rdata = 8'h00;
      endcase
      if (!req.rd)
         next_rdata = rdata;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         func                 <= gpcfg_func_t'(`GPCFG_FUNC_POR);
         switch_on_ratio      <= `GPCFG_DUTY_POR;
         switch_period_select <= `GPCFG_PER_POR;
         prot                 <= `GPCFG_PROT_POR;
         scratch_low_byte     <= 8'h00;
         scratch_high_byte    <= 8'h00;
         lock1_pend           <= 1'b0;
         lock1_pend_seen      <= 1'b1;
         lock1                <= 1'b0;
         charge_pump_on       <= 1'b0;
         rdata                <= 8'h00;
      end else begin
         func                 <= next_func;
         switch_on_ratio      <= next_switch_on_ratio;
         switch_period_select <= next_switch_period_select;
         prot                 <= next_prot;
         scratch_low_byte     <= next_scratch_low_byte;
         scratch_high_byte    <= next_scratch_high_byte;
         lock1_pend           <= next_lock1_pend;
         lock1_pend_seen      <= next_lock1_pend_seen;
         lock1                <= next_lock1;
         charge_pump_on       <= next_charge_pump_on;
         rdata                <= next_rdata;
      end
   end

   // Static filter: level must hold a full window before it is accepted
   always_comb begin
      next_filt_cnt   = filt_cnt;
      next_wake_level = wake_level;
      if (func != GPCFG_FN_WAKE) begin
         next_filt_cnt   = 12'h000;
         next_wake_level = 1'b0;
      end else if (wake_sync[2] != wake_sync[1] || wake_sync[2] == wake_level) begin
         next_filt_cnt = 12'h000;
      end else if (filt_cnt == 12'(FILT_CYC - 1)) begin
         next_filt_cnt   = 12'h000;
         next_wake_level = wake_sync[2];
      end else begin
         next_filt_cnt = filt_cnt + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_cnt   <= 12'h000;
         wake_level <= 1'b0;
      end else begin
         filt_cnt   <= next_filt_cnt;
         wake_level <= next_wake_level;
      end
   end

   always_comb begin
      pin.fail_output  = (func == GPCFG_FN_FAIL0) || (func == GPCFG_FN_FAIL1)
                         || (func == GPCFG_FN_FAIL2);
      pin.cyclic_hs    = (func == GPCFG_FN_CYCHS);
      pin.low_side_on  = (func == GPCFG_FN_PWMLS) && pwm_out;
      pin.high_side_on = (func == GPCFG_FN_PWMHS) && pwm_out;
      pin.wake_enable  = (func == GPCFG_FN_WAKE);
      pin.wake_source  = (func == GPCFG_FN_WAKE) && (mode == GPCFG_MODE_FAILSAFE);
   end

   assign thermal_trip_level   = prot[`GPCFG_PROT_TSD_BIT];
   assign regulator_limit_trim = prot[1:0];
   assign scratch_word         = {scratch_high_byte, scratch_low_byte};
endmodule : gpcfg_regs

// ===== rtl/gpcfg_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GPCFG_PARAMS_SVH
`define GPCFG_PARAMS_SVH
`define GPCFG_ADDR_FUNC       7'h17
`define GPCFG_ADDR_DUTY       7'h18
`define GPCFG_ADDR_PERIOD     7'h1c
`define GPCFG_ADDR_PROT       7'h1d
`define GPCFG_ADDR_SCR_LO     7'h1e
`define GPCFG_ADDR_SCR_HI     7'h1f
`define GPCFG_FUNC_MSB        2
`define GPCFG_PER_MSB         1
`define GPCFG_PROT_TSD_BIT    2
`define GPCFG_PROT_MSB        2
`define GPCFG_FUNC_POR        3'h0
`define GPCFG_DUTY_POR        8'h00
`define GPCFG_PER_POR         2'h0
`define GPCFG_PROT_POR        3'h1
`define GPCFG_CLK_HZ          125000000
`define GPCFG_WAKE_FILT_NS    16000
`define GPCFG_WAKE_FILT_CYC   ((`GPCFG_WAKE_FILT_NS * 125) / 1000)
`define GPCFG_PWM_STEPS       255
`define GPCFG_F0_HZ           100
`define GPCFG_F1_HZ           200
`define GPCFG_F2_HZ           325
`define GPCFG_F3_HZ           400
`define GPCFG_STEP_CYC(f)     (`GPCFG_CLK_HZ / ((f) * `GPCFG_PWM_STEPS))
`endif

// ===== rtl/gpcfg_pkg.sv
// Types shared by the configuration register group
package gpcfg_pkg;
   typedef enum logic [2:0] {
      GPCFG_FN_FAIL0  = 3'h0,
      GPCFG_FN_FAIL1  = 3'h1,
      GPCFG_FN_FAIL2  = 3'h2,
      GPCFG_FN_CYCHS  = 3'h3,
      GPCFG_FN_OFF    = 3'h4,
      GPCFG_FN_WAKE   = 3'h5,
      GPCFG_FN_PWMLS  = 3'h6,
      GPCFG_FN_PWMHS  = 3'h7
   } gpcfg_func_t;

   typedef enum logic [1:0] {
      GPCFG_MODE_NORMAL,
      GPCFG_MODE_STOP,
      GPCFG_MODE_FAILSAFE,
      GPCFG_MODE_RESTART
   } gpcfg_mode_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } gpcfg_req_t;

   typedef struct packed {
      logic fail_output;
      logic cyclic_hs;
      logic low_side_on;
      logic high_side_on;
      logic wake_enable;
      logic wake_source;
   } gpcfg_pin_t;
endpackage : gpcfg_pkg

// ===== rtl/gpcfg_pwm.sv
// Period-aligned switch timer with shadowed duty and frequency
`include "gpcfg_params.svh"
module gpcfg_pwm
   import gpcfg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] duty,
   input  wire logic [1:0] freq,
   output      logic       pwm_out
);
   localparam int C0 = `GPCFG_STEP_CYC(`GPCFG_F0_HZ);
   localparam int C1 = `GPCFG_STEP_CYC(`GPCFG_F1_HZ);
   localparam int C2 = `GPCFG_STEP_CYC(`GPCFG_F2_HZ);
   localparam int C3 = `GPCFG_STEP_CYC(`GPCFG_F3_HZ);

   logic [12:0] div;
   logic [12:0] next_div;
   logic [7:0]  step;
   logic [7:0]  next_step;
   logic [7:0]  duty_act;
   logic [7:0]  next_duty_act;
   logic [1:0]  freq_act;
   logic [1:0]  next_freq_act;
   logic        next_pwm_out;
   logic [12:0] div_top;
   logic        tick;

   always_comb begin
      case (freq_act)
         2'h0:    div_top = 13'(C0 - 1);
         2'h1:    div_top = 13'(C1 - 1);
         2'h2:    div_top = 13'(C2 - 1);
         default: div_top = 13'(C3 - 1);
      endcase
      tick          = (div == div_top);
      next_div      = tick ? 13'h0000 : div + 13'h0001;
      next_step     = step;
      next_duty_act = duty_act;
      next_freq_act = freq_act;
      if (tick) begin
         if (step == 8'(`GPCFG_PWM_STEPS - 1)) begin
            next_step     = 8'h00;
            next_duty_act = duty;
            next_freq_act = freq;
         end else begin
            next_step = step + 8'h01;
         end
      end
      // Full scale forces on so 8'hff never leaves a gap step
      if (duty_act == 8'h00)
         next_pwm_out = 1'b0;
      else if (duty_act == 8'hff)
         next_pwm_out = 1'b1;
      else
         next_pwm_out = (step < duty_act);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div      <= 13'h0000;
         step     <= 8'h00;
         duty_act <= 8'h00;
         freq_act <= 2'h0;
         pwm_out  <= 1'b0;
      end else begin
         div      <= next_div;
         step     <= next_step;
         duty_act <= next_duty_act;
         freq_act <= next_freq_act;
         pwm_out  <= next_pwm_out;
      end
   end
endmodule : gpcfg_pwm

// ===== bench/gpcfg_regs_monitor.sv
// Port-level checker for the configuration register group
module gpcfg_regs_monitor
   import gpcfg_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire gpcfg_req_t  req,
   input wire logic [7:0]  rdata,
   input wire gpcfg_mode_t mode,
   input wire logic        soft_reset,
   input wire logic        restart,
   input wire logic        lock0,
   input wire logic        charge_pump_req,
   input wire logic        lock1,
   input wire logic        charge_pump_on,
   input wire gpcfg_pin_t  pin,
   input wire logic        thermal_trip_level,
   input wire logic [1:0]  regulator_limit_trim,
   input wire logic [15:0] scratch_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Resets win over a write in the same cycle
   wire logic quiet = !soft_reset && !restart;
   wire logic wf    = req.wr && req.addr == 7'h17 && quiet;
   wire logic ws    = req.wr && req.addr[6:1] == 6'h0f;
   a_func_fail: assert property (wf && !lock0 |=>
      pin.fail_output == ($past(req.wdata[2:0]) < 3'h3)) else $error("fail output decode");
   a_func_cyclic: assert property (wf && !lock0 |=>
      pin.cyclic_hs == ($past(req.wdata[2:0]) == 3'h3)) else $error("cyclic decode");
   a_func_wake: assert property (wf && !lock0 |=>
      pin.wake_enable == ($past(req.wdata[2:0]) == 3'h5)) else $error("wake decode");
   a_lock0_func: assert property (wf && lock0 |=>
      $stable(pin.fail_output) && $stable(pin.wake_enable)) else $error("locked func moved");
   a_lock0_pump: assert property (lock0 |=> $stable(charge_pump_on))
      else $error("locked pump moved");
   a_pump_follow: assert property (!lock0 && quiet |=>
      charge_pump_on == $past(charge_pump_req)) else $error("pump not following");
   a_soft_func: assert property (soft_reset && !lock0 |=> pin.fail_output)
      else $error("soft reset func");
   a_por_values: assert property ($rose(rst_n) |-> pin.fail_output &&
      regulator_limit_trim == 2'h1 && !thermal_trip_level && scratch_word == 16'h0000)
      else $error("power-on values");
   a_prot_lock: assert property (lock1 |=>
      $stable({thermal_trip_level, regulator_limit_trim})) else $error("locked prot moved");
   a_scr_keep: assert property (soft_reset || restart |=> $stable(scratch_word))
      else $error("scratch lost");
   a_scr_mode: assert property (ws && mode != GPCFG_MODE_NORMAL |=>
      $stable(scratch_word)) else $error("scratch written outside normal");
   a_scr_high: assert property (ws && req.addr[0] && quiet && mode == GPCFG_MODE_NORMAL
      |=> scratch_word[15:8] == $past(req.wdata)) else $error("high scratch byte");
   a_rd_resv: assert property (req.rd && req.addr == 7'h17 |=> rdata[7:3] == 5'h00)
      else $error("reserved bits set");
endmodule : gpcfg_regs_monitor

bind gpcfg_regs gpcfg_regs_monitor gpcfg_regs_monitor_inst (
   .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .mode(mode),
   .soft_reset(soft_reset), .restart(restart), .lock0(lock0),
   .charge_pump_req(charge_pump_req), .lock1(lock1), .charge_pump_on(charge_pump_on),
   .pin(pin), .thermal_trip_level(thermal_trip_level),
   .regulator_limit_trim(regulator_limit_trim), .scratch_word(scratch_word)
);

// ===== bench/gpcfg_host.sv
// Host controller model issuing register cycles
module gpcfg_host
   import gpcfg_pkg::*;
(
   input  wire logic       clk,
   output gpcfg_req_t      req,
   input  wire logic [7:0] rdata
);
   initial req = '0;
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{1'b1, 1'b0, a, d};
      @(posedge clk);
      // Released data does not keep its old value
      #1 req = '{1'b0, 1'b0, a, ~d};
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 req = '{1'b0, 1'b1, a, 8'h5a};
      @(posedge clk);
      #1 req.rd = 1'b0;
      d = rdata;
   endtask : rd
endmodule : gpcfg_host

// ===== bench/gpcfg_regs_tb_top.sv
// Self-checking bench for the configuration register group
module gpcfg_regs_tb_top
   import gpcfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, select_n, soft_reset, restart;
   logic        lock0, lock1_set, charge_pump_req, wake_pin;
   logic        lock1, charge_pump_on, wake_level, thermal_trip_level;
   logic [1:0]  regulator_limit_trim;
   logic [7:0]  rdata;
   logic [15:0] scratch_word;
   gpcfg_mode_t mode;
   gpcfg_req_t  req;
   gpcfg_pin_t  pin;
   int          num_errors = 0, n_compared = 0, cyc = 0;

   gpcfg_regs gpcfg_regs_inst (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .select_n(select_n), .mode(mode), .soft_reset(soft_reset), .restart(restart),
      .lock0(lock0), .lock1_set(lock1_set), .charge_pump_req(charge_pump_req),
      .wake_pin(wake_pin), .lock1(lock1), .charge_pump_on(charge_pump_on), .pin(pin),
      .wake_level(wake_level), .thermal_trip_level(thermal_trip_level),
      .regulator_limit_trim(regulator_limit_trim), .scratch_word(scratch_word));
   gpcfg_host gpcfg_host_inst (.clk(clk), .req(req), .rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      gpcfg_host_inst.wr(a, d);
   endtask : wr
   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      gpcfg_host_inst.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask : rc
   task automatic pulse(ref logic s);
      @(posedge clk);
      #1 s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
   endtask : pulse

   task t_por;
      rc(7'h17, 8'h00);
      rc(7'h18, 8'h00);
      rc(7'h1c, 8'h00);
      rc(7'h1d, 8'h01);
      rc(7'h1e, 8'h00);
      rc(7'h1f, 8'h00);
      rc(7'h10, 8'h00);
      $display("t_por done");
   endtask : t_por

   task t_func;
      for (int c = 0; c < 8; c++) begin
         wr(7'h17, {5'h1f, c[2:0]});
         rc(7'h17, {5'h00, c[2:0]});
         chk("fail_output", c < 3, pin.fail_output);
         chk("cyclic_hs", c == 3, pin.cyclic_hs);
         chk("wake_enable", c == 5, pin.wake_enable);
         // Duty is still zero, so both switch codes stay dark
         chk("pin", 0, (c == 4 || c > 5) && |pin);
      end
      $display("t_func done");
   endtask : t_func

   task t_pwm;
      wr(7'h17, 8'h00);
      wr(7'h18, 8'hff);
      for (int f = 0; f < 4; f++) begin
         wr(7'h1c, {6'h3f, f[1:0]});
         rc(7'h1c, {6'h00, f[1:0]});
      end
      wr(7'h17, 8'h06);
      repeat (300) @(posedge clk);
      // Period in flight still runs the old zero duty
      chk("low_side_on", 0, pin.low_side_on);
      pulse(restart);
      rc(7'h18, 8'hff);
      rc(7'h1c, 8'h00);
      $display("t_pwm done");
   endtask : t_pwm

   task t_lock;
      lock0 = 1'b1;
      charge_pump_req = 1'b1;
      wr(7'h17, 8'h03);
      rc(7'h17, 8'h06);
      chk("charge_pump_on", 0, charge_pump_on);
      pulse(soft_reset);
      rc(7'h17, 8'h06);
      rc(7'h18, 8'h00);
      lock0 = 1'b0;
      wr(7'h1d, 8'hfe);
      chk("charge_pump_on", 1, charge_pump_on);
      chk("thermal_trip_level", 1, thermal_trip_level);
      chk("regulator_limit_trim", 2, regulator_limit_trim);
      pulse(lock1_set);
      select_n = 1'b0;
      repeat (6) @(posedge clk);
      chk("lock1", 0, lock1);
      #1 select_n = 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("lock1", 1, lock1);
      wr(7'h1d, 8'h01);
      pulse(soft_reset);
      rc(7'h1d, 8'h06);
      rc(7'h17, 8'h00);
      $display("t_lock done");
   endtask : t_lock

   task t_scratch;
      wr(7'h1e, 8'ha5);
      wr(7'h1f, 8'h3c);
      chk("scratch_word", 16'h3ca5, scratch_word);
      mode = GPCFG_MODE_STOP;
      wr(7'h1e, 8'h00);
      rc(7'h1e, 8'ha5);
      pulse(soft_reset);
      pulse(restart);
      mode = GPCFG_MODE_NORMAL;
      chk("scratch_word", 16'h3ca5, scratch_word);
      $display("t_scratch done");
   endtask : t_scratch

   task t_wake;
      mode = GPCFG_MODE_FAILSAFE;
      wr(7'h17, 8'h05);
      chk("wake_source", 1, pin.wake_source);
      wake_pin = 1'b1;
      repeat (1900) @(posedge clk);
      chk("wake_level", 0, wake_level);
      repeat (200) @(posedge clk);
      chk("wake_level", 1, wake_level);
      $display("t_wake done");
   endtask : t_wake

   task tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   initial begin
      rst_n = 1'b0;
      mode = GPCFG_MODE_NORMAL;
      {soft_reset, restart, lock0, lock1_set} = 4'h0;
      {select_n, charge_pump_req, wake_pin} = 3'h4;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      t_por();
      t_func();
      t_pwm();
      t_lock();
      t_scratch();
      t_wake();
      tally_and_finish();
   end
endmodule : gpcfg_regs_tb_top
